// >>> ect_pkg.sv
package ect_pkg;
    localparam logic [5:0] ADDR_DIR = 6'h00;
    localparam logic [5:0] ADDR_FORCE = 6'h01;
    localparam logic [5:0] ADDR_C7MASK = 6'h02;
    localparam logic [5:0] ADDR_C7VAL = 6'h03;
    localparam logic [5:0] ADDR_PORT_DATA = 6'h04;
    localparam logic [5:0] ADDR_PORT_DIR = 6'h05;
    localparam logic [5:0] ADDR_ACT_HI = 6'h06;
    localparam logic [5:0] ADDR_ACT_LO = 6'h07;
    localparam logic [5:0] ADDR_EDGE_HI = 6'h08;
    localparam logic [5:0] ADDR_EDGE_LO = 6'h09;
    localparam logic [5:0] ADDR_PROTECT = 6'h0a;
    localparam logic [5:0] ADDR_SYSCTL = 6'h0b;
    localparam logic [5:0] ADDR_MODCTL = 6'h0c;
    localparam logic [5:0] ADDR_MODCNT = 6'h0d;
    localparam logic [5:0] ADDR_STATUS = 6'h0e;
    localparam logic [5:0] ADDR_CHAN = 6'h10;
    localparam logic [5:0] ADDR_HOLD = 6'h18;
    localparam logic [5:0] ADDR_ACC = 6'h1c;
    localparam logic [5:0] ADDR_ACC_HOLD = 6'h20;
    localparam int SYS_LATCH_OR_QUEUE_SELECT = 0;
    localparam int SYS_SAT = 1;
    localparam int SYS_PAIR_LO = 2;
    localparam int SYS_PAIR_HI = 3;
    localparam int MOD_LATCH_EN = 0;
    localparam int MOD_ONESHOT = 1;
    localparam int MOD_FORCE_LATCH = 2;
    localparam int MOD_RUN = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
endpackage

// >>> ect_timer.sv
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - direction bit: 0 capture, 1 compare
// - channels 0-3 have holding buffer
// - read or transfer marks register empty
// - plain capture overwrites unless protected and full
// - latch mode copies on zero/write0/force
// - unprotected latch overwrites both registers
// - protected registers written only when empty
// - queue mode shifts capture into holding
// - queue holding read latches and clears accumulator
// - accumulators count active edges per buffered channel
// - saturate control stops unpaired accumulators at ff
// - accumulator pairs chain into 16 bits
// - latch copies and clears accumulators
// - modulus counter latches periodically or once
// - enabled compare forces pin to output
// - port data written while claimed is held
// - force bits act without flag, read zero
// - channel-7 mask forces compare pin output
// - channel-7 match loads masked data bits
// - channel-7 mask beats per-channel action
// - action codes: off, toggle, low, high
module ect_timer (
    input wire logic clk_i, // 125 MHz module clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic [15:0] count_i, // main timer count
    input wire logic [5:0] addr_i, // register address
    input wire logic [15:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [15:0] rdata_o, // read data, cycle after rd_i
    input wire logic [7:0] pin_i, // timer port pin levels
    output logic [7:0] pin_o, // timer port drive value
    output logic [7:0] pin_oe_n_o, // low while pin is driven
    output logic [7:0] flag_o // compare/capture events (sticky)
);
    typedef struct packed {
        logic [7:0] dir, c7mask, c7val, port_data, port_dir, oc_out, protect, flags;
        logic [15:0] act, edges;
        logic [3:0] sys;
        logic [3:0] modctl;
        logic [15:0] mod_load, mod_cnt;
        logic mod_done;
        logic [7:0][15:0] chan;
        logic [7:0] chan_full;
        logic [3:0][15:0] hold;
        logic [3:0] hold_full;
        logic [3:0][7:0] acc, acc_hold;
        logic [7:0] sync1, sync2, prev;
        logic [15:0] rdata;
        logic [7:0] pin, pin_oe_n;
    } ect_state_t;

    ect_state_t st_reg, st_next;
    logic [7:0] rise, fall, active, claimed;
    logic [7:0] oc_match, oc_fire, nxt_out;
    logic latch_ev, mod_zero;
    logic [8:0] sum;
    logic [3:0] acc_inc;
    logic wr_dir, wr_force, wr_act_hi, wr_act_lo, wr_edge_hi, wr_edge_lo, wr_modcnt;

    always_comb begin
        st_next = st_reg;
        sum = 9'h000;
        // write-one clear goes first so that a hardware set in the same cycle wins
        if (wr_i && addr_i == ect_pkg::ADDR_STATUS) begin
            st_next.flags = st_reg.flags & ~wdata_i[7:0];
        end
        wr_dir = wr_i && addr_i == ect_pkg::ADDR_DIR;
        wr_force = wr_i && addr_i == ect_pkg::ADDR_FORCE;
        wr_act_hi = wr_i && addr_i == ect_pkg::ADDR_ACT_HI;
        wr_act_lo = wr_i && addr_i == ect_pkg::ADDR_ACT_LO;
        wr_edge_hi = wr_i && addr_i == ect_pkg::ADDR_EDGE_HI;
        wr_edge_lo = wr_i && addr_i == ect_pkg::ADDR_EDGE_LO;
        wr_modcnt = wr_i && addr_i == ect_pkg::ADDR_MODCNT;
        // second stage and its delayed copy prev feed edge logic; first stage is metastability guard
        st_next.sync1 = pin_i;
        st_next.sync2 = st_reg.sync1;
        st_next.prev = st_reg.sync2;
        rise = st_reg.sync2 & ~st_reg.prev;
        fall = ~st_reg.sync2 & st_reg.prev;
        for (int i = 0; i < 8; i++) begin
            active[i] = (st_reg.edges[2*i] & rise[i]) | (st_reg.edges[2*i+1] & fall[i]);
        end
        // modulus down-counter
        mod_zero = 1'b0;
        if (st_reg.modctl[ect_pkg::MOD_RUN] && !st_reg.mod_done) begin
            if (st_reg.mod_cnt == ect_pkg::RESET_WORD) begin
                st_next.mod_cnt = st_reg.mod_load;
                mod_zero = 1'b1;
                if (st_reg.modctl[ect_pkg::MOD_ONESHOT]) begin
                    st_next.mod_done = 1'b1;
                end
            end else begin
                st_next.mod_cnt = st_reg.mod_cnt - 16'h0001;
            end
        end
        latch_ev = st_reg.sys[ect_pkg::SYS_LATCH_OR_QUEUE_SELECT] && ((mod_zero && st_reg.modctl[ect_pkg::MOD_LATCH_EN])
            || (wr_modcnt && wdata_i == ect_pkg::RESET_WORD)
            || (wr_i && addr_i == ect_pkg::ADDR_MODCTL && wdata_i[ect_pkg::MOD_FORCE_LATCH]));
        // reads empty the registers before any event of this cycle refills them
        for (int i = 0; i < 8; i++) begin
            if (rd_i && addr_i == ect_pkg::ADDR_CHAN + 6'(i)) begin
                st_next.chan_full[i] = 1'b0;
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (rd_i && addr_i == ect_pkg::ADDR_HOLD + 6'(i)) begin
                st_next.hold_full[i] = 1'b0;
                if (!st_reg.sys[ect_pkg::SYS_LATCH_OR_QUEUE_SELECT]) begin
                    st_next.acc_hold[i] = st_reg.acc[i];
                    st_next.acc[i] = ect_pkg::RESET_BYTE;
                end
            end
        end
        // capture channels; 0-3 are the buffered ones
        for (int i = 0; i < 8; i++) begin
            if (!st_reg.dir[i] && active[i]) begin
                // i%4 keeps the unbuffered iterations inside the four holding entries
                if (i < 4 && !st_reg.sys[ect_pkg::SYS_LATCH_OR_QUEUE_SELECT]) begin
                    if (!st_reg.protect[i]) begin
                        st_next.hold[i%4] = st_reg.chan[i];
                        st_next.hold_full[i%4] = st_reg.chan_full[i];
                        st_next.chan[i] = count_i;
                        st_next.chan_full[i] = 1'b1;
                    end else if (!st_next.chan_full[i]) begin
                        st_next.chan[i] = count_i;
                        st_next.chan_full[i] = 1'b1;
                    end else if (!st_next.hold_full[i%4]) begin
                        st_next.hold[i%4] = st_reg.chan[i];
                        st_next.hold_full[i%4] = 1'b1;
                        st_next.chan[i] = count_i;
                    end
                end else if (!st_reg.protect[i] || !st_next.chan_full[i]) begin
                    st_next.chan[i] = count_i;
                    st_next.chan_full[i] = 1'b1;
                end
                st_next.flags[i] = 1'b1;
            end
        end
        // accumulators count edges on the buffered inputs
        for (int i = 0; i < 4; i++) begin
            acc_inc[i] = active[i];
        end
        for (int i = 0; i < 4; i++) begin
            if (acc_inc[i] && !(i[0] && st_reg.sys[ect_pkg::SYS_PAIR_LO + i/2])) begin
                sum = {1'b0, st_next.acc[i]} + 9'h001;
                if (sum[8] && st_reg.sys[ect_pkg::SYS_SAT] && !st_reg.sys[ect_pkg::SYS_PAIR_LO + i/2]) begin
                    st_next.acc[i] = 8'hff;
                end else begin
                    st_next.acc[i] = sum[7:0];
                    if (sum[8] && !i[0] && st_reg.sys[ect_pkg::SYS_PAIR_LO + i/2]) begin
                        st_next.acc[i|1] = st_next.acc[i|1] + 8'h01;
                    end
                end
            end
        end
        // latch transfers, copy then clear
        if (latch_ev) begin
            for (int i = 0; i < 4; i++) begin
                if (!st_reg.protect[i] || !st_next.hold_full[i]) begin
                    st_next.hold[i] = st_next.chan[i];
                    st_next.hold_full[i] = st_next.chan_full[i];
                    st_next.chan_full[i] = 1'b0;
                end
                st_next.acc_hold[i] = st_next.acc[i];
                st_next.acc[i] = ect_pkg::RESET_BYTE;
            end
        end
        // output compare
        for (int i = 0; i < 8; i++) begin
            oc_match[i] = st_reg.dir[i] && st_reg.chan[i] == count_i;
            oc_fire[i] = oc_match[i] || (wr_force && wdata_i[i] && st_reg.dir[i]);
            if (oc_match[i]) begin
                st_next.flags[i] = 1'b1;
            end
        end
        nxt_out = st_reg.oc_out;
        for (int i = 0; i < 8; i++) begin
            if (oc_fire[i] && !st_reg.c7mask[i]) begin
                case (st_reg.act[2*i +: 2])
                    2'b01: nxt_out[i] = ~st_reg.oc_out[i];
                    2'b10: nxt_out[i] = 1'b0;
                    2'b11: nxt_out[i] = 1'b1;
                    default: nxt_out[i] = st_reg.oc_out[i];
                endcase
            end
            if (oc_fire[7] && st_reg.c7mask[i]) begin
                nxt_out[i] = st_reg.c7val[i];
            end
        end
        st_next.oc_out = nxt_out;
        for (int i = 0; i < 8; i++) begin
            claimed[i] = st_reg.dir[i] && (st_reg.act[2*i +: 2] != 2'b00 || st_reg.c7mask[i]);
        end
        st_next.pin = (claimed & nxt_out) | (~claimed & st_reg.port_data);
        st_next.pin_oe_n = ~(claimed | st_reg.port_dir);
        // register writes
        if (wr_dir) st_next.dir = wdata_i[7:0];
        if (wr_i && addr_i == ect_pkg::ADDR_C7MASK) st_next.c7mask = wdata_i[7:0];
        if (wr_i && addr_i == ect_pkg::ADDR_C7VAL) st_next.c7val = wdata_i[7:0];
        if (wr_i && addr_i == ect_pkg::ADDR_PORT_DATA) st_next.port_data = wdata_i[7:0];
        if (wr_i && addr_i == ect_pkg::ADDR_PORT_DIR) st_next.port_dir = wdata_i[7:0];
        if (wr_act_hi) st_next.act[15:8] = wdata_i[7:0];
        if (wr_act_lo) st_next.act[7:0] = wdata_i[7:0];
        if (wr_edge_hi) st_next.edges[15:8] = wdata_i[7:0];
        if (wr_edge_lo) st_next.edges[7:0] = wdata_i[7:0];
        if (wr_i && addr_i == ect_pkg::ADDR_PROTECT) st_next.protect = wdata_i[7:0];
        if (wr_i && addr_i == ect_pkg::ADDR_SYSCTL) st_next.sys = wdata_i[3:0];
        if (wr_i && addr_i == ect_pkg::ADDR_MODCTL) begin
            st_next.modctl = {wdata_i[3], 1'b0, wdata_i[1:0]};
            st_next.mod_done = 1'b0;
        end
        if (wr_modcnt) begin
            st_next.mod_load = wdata_i;
            st_next.mod_cnt = wdata_i;
            st_next.mod_done = 1'b0;
        end
        for (int i = 0; i < 8; i++) begin
            if (wr_i && addr_i == ect_pkg::ADDR_CHAN + 6'(i)) st_next.chan[i] = wdata_i;
        end
        // read mux
        st_next.rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                ect_pkg::ADDR_DIR: st_next.rdata = {8'h00, st_reg.dir};
                ect_pkg::ADDR_FORCE: st_next.rdata = 16'h0000;
                ect_pkg::ADDR_C7MASK: st_next.rdata = {8'h00, st_reg.c7mask};
                ect_pkg::ADDR_C7VAL: st_next.rdata = {8'h00, st_reg.c7val};
                ect_pkg::ADDR_PORT_DATA: st_next.rdata = {8'h00, st_reg.sync2};
                ect_pkg::ADDR_PORT_DIR: st_next.rdata = {8'h00, st_reg.port_dir};
                ect_pkg::ADDR_ACT_HI: st_next.rdata = {8'h00, st_reg.act[15:8]};
                ect_pkg::ADDR_ACT_LO: st_next.rdata = {8'h00, st_reg.act[7:0]};
                ect_pkg::ADDR_EDGE_HI: st_next.rdata = {8'h00, st_reg.edges[15:8]};
                ect_pkg::ADDR_EDGE_LO: st_next.rdata = {8'h00, st_reg.edges[7:0]};
                ect_pkg::ADDR_PROTECT: st_next.rdata = {8'h00, st_reg.protect};
                ect_pkg::ADDR_SYSCTL: st_next.rdata = {12'h000, st_reg.sys};
                ect_pkg::ADDR_MODCTL: st_next.rdata = {12'h000, st_reg.modctl};
                ect_pkg::ADDR_MODCNT: st_next.rdata = st_reg.mod_cnt;
                ect_pkg::ADDR_STATUS: st_next.rdata = {st_reg.chan_full, st_reg.flags};
                default: begin
                    for (int i = 0; i < 8; i++) begin
                        if (addr_i == ect_pkg::ADDR_CHAN + 6'(i)) st_next.rdata = st_reg.chan[i];
                    end
                    for (int i = 0; i < 4; i++) begin
                        if (addr_i == ect_pkg::ADDR_HOLD + 6'(i)) st_next.rdata = st_reg.hold[i];
                        if (addr_i == ect_pkg::ADDR_ACC + 6'(i)) st_next.rdata = {8'h00, st_reg.acc[i]};
                        if (addr_i == ect_pkg::ADDR_ACC_HOLD + 6'(i)) st_next.rdata = {8'h00, st_reg.acc_hold[i]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
            st_reg.pin_oe_n <= 8'hff;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.rdata;
    assign pin_o = st_reg.pin;
    assign pin_oe_n_o = st_reg.pin_oe_n;
    assign flag_o = st_reg.flags;

    property p_force_reads_zero;
        @(posedge clk_i) disable iff (!rst_n_i) (rd_i && addr_i == ect_pkg::ADDR_FORCE) |=> rdata_o == 16'h0000;
    endproperty
    a_force_reads_zero: assert property (p_force_reads_zero) else $error("force register read nonzero");

    property p_claim_drives;
        @(posedge clk_i) disable iff (!rst_n_i) (st_reg.dir[2] && st_reg.act[5:4] != 2'b00) |=> !pin_oe_n_o[2];
    endproperty
    a_claim_drives: assert property (p_claim_drives) else $error("claimed pin not driven");

    property p_sync_delay;
        @(posedge clk_i) disable iff (!rst_n_i) $rose(st_reg.sync2[3]) |-> $past(pin_i[3], 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync stage bypassed");

    property p_force_no_flag;
        @(posedge clk_i) disable iff (!rst_n_i)
            (wr_force && wdata_i[2] && st_reg.dir[2] && !oc_match[2] && !flag_o[2]) |=> !flag_o[2];
    endproperty
    a_force_no_flag: assert property (p_force_no_flag) else $error("force set a flag");

    property p_toggle_action;
        @(posedge clk_i) disable iff (!rst_n_i)
            (wr_force && wdata_i[2] && st_reg.dir[2] && st_reg.act[5:4] == 2'b01 && !st_reg.c7mask[2])
            |=> pin_o[2] != $past(st_reg.oc_out[2]);
    endproperty
    a_toggle_action: assert property (p_toggle_action) else $error("toggle action did not toggle");

    property p_mask_drives;
        @(posedge clk_i) disable iff (!rst_n_i)
            (st_reg.dir[2] && st_reg.c7mask[2]) |=> !pin_oe_n_o[2];
    endproperty
    a_mask_drives: assert property (p_mask_drives) else $error("masked compare pin not driven");

    property p_c7_override;
        @(posedge clk_i) disable iff (!rst_n_i)
            (oc_match[7] && st_reg.dir[2] && st_reg.c7mask[2]) |=> pin_o[2] == $past(st_reg.c7val[2]);
    endproperty
    a_c7_override: assert property (p_c7_override) else $error("channel-7 data not applied");

    property p_unclaimed_port;
        @(posedge clk_i) disable iff (!rst_n_i)
            !st_reg.dir[2] |=> pin_o[2] == $past(st_reg.port_data[2]);
    endproperty
    a_unclaimed_port: assert property (p_unclaimed_port) else $error("free pin not at port latch");

    property p_acc_saturate;
        @(posedge clk_i) disable iff (!rst_n_i)
            (st_reg.sys[ect_pkg::SYS_SAT] && !st_reg.sys[ect_pkg::SYS_PAIR_HI] && st_reg.acc[3] == 8'hff
            && !latch_ev && !(rd_i && addr_i == ect_pkg::ADDR_HOLD + 6'h03)) |=> st_reg.acc[3] == 8'hff;
    endproperty
    a_acc_saturate: assert property (p_acc_saturate) else $error("saturated accumulator moved");

    property p_latch_clears_acc;
        @(posedge clk_i) disable iff (!rst_n_i)
            latch_ev |=> st_reg.acc == 32'h00000000;
    endproperty
    a_latch_clears_acc: assert property (p_latch_clears_acc) else $error("latch left accumulator");

    property p_oneshot_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
            (st_reg.modctl[ect_pkg::MOD_RUN] && st_reg.mod_done && !wr_i) |=> $stable(st_reg.mod_cnt);
    endproperty
    a_oneshot_hold: assert property (p_oneshot_hold) else $error("one-shot counter kept running");

    property p_queue_shift;
        @(posedge clk_i) disable iff (!rst_n_i)
            (!st_reg.sys[ect_pkg::SYS_LATCH_OR_QUEUE_SELECT] && !st_reg.dir[0] && !st_reg.protect[0] && active[0] && !wr_i)
            |=> st_reg.hold[0] == $past(st_reg.chan[0]) && st_reg.chan[0] == $past(count_i);
    endproperty
    a_queue_shift: assert property (p_queue_shift) else $error("queue capture did not shift");

    property p_protect_keeps;
        @(posedge clk_i) disable iff (!rst_n_i)
            (!st_reg.dir[4] && st_reg.protect[4] && st_reg.chan_full[4] && !rd_i && !wr_i) |=> $stable(st_reg.chan[4]);
    endproperty
    a_protect_keeps: assert property (p_protect_keeps) else $error("protected capture overwritten");

    property p_read_empties;
        @(posedge clk_i) disable iff (!rst_n_i)
            (rd_i && addr_i == ect_pkg::ADDR_CHAN + 6'h04 && !active[4]) |=> !st_reg.chan_full[4];
    endproperty
    a_read_empties: assert property (p_read_empties) else $error("read left capture full");
endmodule // ect_timer
`default_nettype wire

// >>> ect_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module ect_pin_model (
    input wire logic [7:0] drv_i, // drive value from the timer
    input wire logic [7:0] drv_oe_n_i, // low while the timer drives
    input wire logic [7:0] ext_i, // level the outside source drives
    output logic [7:0] pin_o // resolved pin level
);
    // a released pin shows the outside source, never a stale timer value
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            pin_o[b] = drv_oe_n_i[b] ? ext_i[b] : drv_i[b];
        end
    end
endmodule // ect_pin_model
`default_nettype wire

// >>> ect_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module ect_timer_bench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [5:0] addr_i = 6'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic [15:0] count_i = 16'h0000;
    logic [15:0] rdata_o;
    logic [7:0] pin_i, pin_o, pin_oe_n_o, flag_o;
    logic [7:0] ext_lvl = 8'h00;
    int fail_count = 0;
    int n_tests = 0;

    ect_timer dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .count_i(count_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .flag_o(flag_o));
    ect_pin_model pins (.drv_i(pin_o), .drv_oe_n_i(pin_oe_n_o), .ext_i(ext_lvl), .pin_o(pin_i));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [5:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK(nm, e, rdata_o)
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // count is held still across a pulse so the captured value is exact
    task automatic pulse(input int ch, input logic [15:0] cnt);
        @(posedge clk_i);
        count_i <= cnt;
        ext_lvl[ch] <= 1'b1;
        repeat (3) @(posedge clk_i);
        ext_lvl[ch] <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic t_reset;
        `CHK("oe_rst", 8'hff, pin_oe_n_o)
        `CHK("flag_rst", 8'h00, flag_o)
        wr(ect_pkg::ADDR_DIR, 16'h0081);
        rd("dir", ect_pkg::ADDR_DIR, 16'h0081);
        wr(ect_pkg::ADDR_DIR, 16'h0000);
        rd("unmapped", 6'h3f, 16'h0000);
        wr(ect_pkg::ADDR_EDGE_LO, 16'h0055);
        wr(ect_pkg::ADDR_EDGE_HI, 16'h0001);
    endtask

    task automatic t_plain;
        wr(ect_pkg::ADDR_PROTECT, 16'h0010);
        pulse(4, 16'haaaa);
        pulse(4, 16'hbbbb);
        `CHK("flag4", 1'b1, flag_o[4])
        rd("prot", ect_pkg::ADDR_CHAN + 6'h04, 16'haaaa);
        pulse(4, 16'hcccc);
        rd("after_rd", ect_pkg::ADDR_CHAN + 6'h04, 16'hcccc);
    endtask

    task automatic t_queue;
        pulse(0, 16'h1234);
        pulse(0, 16'h5678);
        rd("acc0", ect_pkg::ADDR_ACC, 16'h0002);
        rd("chan0", ect_pkg::ADDR_CHAN, 16'h5678);
        rd("hold0", ect_pkg::ADDR_HOLD, 16'h1234);
        rd("acch0", ect_pkg::ADDR_ACC_HOLD, 16'h0002);
        rd("acc0_clr", ect_pkg::ADDR_ACC, 16'h0000);
    endtask

    task automatic t_latch;
        wr(ect_pkg::ADDR_SYSCTL, 16'h0003);
        pulse(1, 16'h1111);
        wr(ect_pkg::ADDR_MODCTL, 16'h0005);
        pulse(1, 16'h2222);
        pulse(1, 16'h2222);
        wr(ect_pkg::ADDR_MODCNT, 16'h0000);
        rd("hold1", ect_pkg::ADDR_HOLD + 6'h01, 16'h2222);
        rd("acch1", ect_pkg::ADDR_ACC_HOLD + 6'h01, 16'h0002);
        rd("acc1", ect_pkg::ADDR_ACC + 6'h01, 16'h0000);
        repeat (257) pulse(3, 16'h0000);
        rd("sat3", ect_pkg::ADDR_ACC + 6'h03, 16'h00ff);
        wr(ect_pkg::ADDR_SYSCTL, 16'h0009);
        wr(ect_pkg::ADDR_MODCNT, 16'h0000);
        repeat (256) pulse(2, 16'h0000);
        rd("pair_lo", ect_pkg::ADDR_ACC + 6'h02, 16'h0000);
        rd("pair_hi", ect_pkg::ADDR_ACC + 6'h03, 16'h0001);
        pulse(1, 16'h3333);
        wr(ect_pkg::ADDR_MODCNT, 16'h0003);
        wr(ect_pkg::ADDR_MODCTL, 16'h000b);
        settle(8);
        rd("mod_latch", ect_pkg::ADDR_HOLD + 6'h01, 16'h3333);
        pulse(1, 16'h4444);
        settle(8);
        rd("mod_once", ect_pkg::ADDR_HOLD + 6'h01, 16'h3333);
    endtask

    // forces with high, toggle, toggle, low codes, ending at 0 so the held-write check is visible
    task automatic t_compare;
        logic [15:0] act [4] = '{16'h0030, 16'h0010, 16'h0010, 16'h0020};
        logic exp_lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        count_i <= 16'hffff;
        wr(ect_pkg::ADDR_STATUS, 16'h00ff);
        wr(ect_pkg::ADDR_DIR, 16'h0084);
        wr(ect_pkg::ADDR_CHAN + 6'h02, 16'h4000);
        wr(ect_pkg::ADDR_CHAN + 6'h07, 16'h4000);
        wr(ect_pkg::ADDR_PORT_DIR, 16'h0004);
        settle(4);
        `CHK("gpio_oe", 1'b0, pin_oe_n_o[2])
        `CHK("flag_clr", 8'h00, flag_o)
        for (int i = 0; i < 4; i++) begin
            wr(ect_pkg::ADDR_ACT_LO, act[i]);
            wr(ect_pkg::ADDR_FORCE, 16'h0004);
            settle(4);
            `CHK("force_lvl", exp_lvl[i], pin_o[2])
        end
        `CHK("force_noflag", 1'b0, flag_o[2])
        rd("force_rd", ect_pkg::ADDR_FORCE, 16'h0000);
        wr(ect_pkg::ADDR_PORT_DATA, 16'h0004);
        settle(4);
        `CHK("held", 1'b0, pin_o[2])
        wr(ect_pkg::ADDR_ACT_LO, 16'h0030);
        wr(ect_pkg::ADDR_FORCE, 16'h0004);
        wr(ect_pkg::ADDR_PORT_DIR, 16'h0000);
        wr(ect_pkg::ADDR_ACT_LO, 16'h0000);
        wr(ect_pkg::ADDR_C7MASK, 16'h0004);
        wr(ect_pkg::ADDR_C7VAL, 16'h0000);
        wr(ect_pkg::ADDR_ACT_LO, 16'h0030);
        @(posedge clk_i);
        count_i <= 16'h4000;
        @(posedge clk_i);
        count_i <= 16'hffff;
        settle(4);
        `CHK("c7_lvl", 1'b0, pin_o[2])
        `CHK("c7_oe", 1'b0, pin_oe_n_o[2])
        `CHK("c7_flag", 1'b1, flag_o[7])
        rd("c7_dir", ect_pkg::ADDR_PORT_DIR, 16'h0000);
        wr(ect_pkg::ADDR_ACT_LO, 16'h0000);
        wr(ect_pkg::ADDR_C7MASK, 16'h0000);
        wr(ect_pkg::ADDR_PORT_DIR, 16'h0004);
        settle(4);
        `CHK("gpio_held", 1'b1, pin_o[2])
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        $display("BAD watchdog exp done got hang");
        finish_test();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        settle(1);
        t_reset();
        t_plain();
        t_queue();
        t_latch();
        t_compare();
        finish_test();
    end
endmodule // ect_timer_bench
`default_nettype wire
